// file: rtl/fault_resp_map.svh
/*
 Command codes, field positions, reset values and timing figures for the
 current fault response controller. Definitions only.
*/
`ifndef FAULT_RESP_MAP_SVH
`define FAULT_RESP_MAP_SVH

`define CMD_OC_REACTION 8'he5
`define CMD_UC_REACTION 8'he6
`define REACTION_RESET 8'h80
`define RESP_MODE_HI 7
`define RESP_MODE_LO 6
`define RETRY_CNT_HI 5
`define RETRY_CNT_LO 3
`define RETRY_TIME_HI 2
`define RETRY_TIME_LO 0
`define MODE_RETRY 2'h2
`define MODE_RESUME 2'h3
`define RETRY_NONE 3'h0
`define RETRY_ENDLESS 3'h7
`define RETRY_UNIT_MS 35
`define CORE_CLK_KHZ 40000

`endif

// file: rtl/fault_resp_pkg.sv
/*
 Types for the current fault response controller.
 Assumes fault_resp_map.svh for all numeric constants except the state codes set here.
*/
package fault_resp_pkg;
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RUN = 3'h1,
		ST_DELAY = 3'h3,
		ST_LATCH = 3'h2,
		ST_RESUME = 3'h6
	} resp_state_e;
endpackage : fault_resp_pkg

// file: rtl/current_fault_response_control.sv
/*
 Overcurrent / undercurrent fault response controller: two byte-wide
 reaction registers reached by command code, output enable sequencing with
 retry or resume, sticky status bits and the active-low alert line.
 Assumes a command decoder on i_core_clk presents one strobe per access, and
 asynchronous fault comparator levels on i_oc_fault / i_uc_fault.
*/
// Behaviour
// - Overcurrent reaction byte at command 0xE5, readable and writable.
// - Undercurrent reaction byte at command 0xE6, same layout as overcurrent.
// - Overcurrent response sets the overcurrent status bit.
// - Undercurrent response sets the undercurrent status bit.
// - Every response mode drives the alert line low and sets status.
// - Mode 10 disables output at once, then retries per retry count.
// - Mode 11 disables output, re-enables it once the fault is gone.
// - Retry mode attempts the number of restarts given by the count field.
// - Retry count 000 never restarts; output stays off until faults cleared or output commanded off and on again.
// - Retry count 111 retries forever until commanded off or another stop.
// - Delay between restarts is (retry time + 1) times 35 ms.
`timescale 1ns/100ps
`include "fault_resp_map.svh"
module current_fault_response_control
	import fault_resp_pkg::*;
#(
	parameter int RETRY_UNIT_CYCLES = `RETRY_UNIT_MS * `CORE_CLK_KHZ,
	parameter int TIMER_W = $clog2(8 * RETRY_UNIT_CYCLES + 1)
)(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Command access
	input wire logic [7:0] i_cmd_code,
	input wire logic i_wr_stb,
	input wire logic [7:0] i_wr_data,
	input wire logic i_rd_stb,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_cmd_nack,
	// Control
	input wire logic i_output_on,
	input wire logic i_clear_faults,
	// Fault comparators, asynchronous
	input wire logic i_oc_fault,
	input wire logic i_uc_fault,
	// Results
	output logic o_output_enable,
	output logic o_status_oc,
	output logic o_status_uc,
	output logic o_alert_line_n
);

	if (RETRY_UNIT_CYCLES < 1 || TIMER_W < $clog2(8 * RETRY_UNIT_CYCLES + 1))
	begin : g_bad_params
		$error("current_fault_response_control: bad timer parameters");
	end
	logic [7:0] oc_cfg_reg, uc_cfg_reg;
	logic [1:0] fault_filt;
	resp_state_e state_reg, state_next;
	logic [2:0] retries_left_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic cause_uc_reg, retry_active_reg, out_en_reg, stat_oc_reg, stat_uc_reg, alert_n_reg;
	// Three-stage sync; filtered level moves only when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_sync
			logic s1_reg, s2_reg, s3_reg, filt_reg;
			always_ff @(posedge i_core_clk)
			begin
				if (!i_rst_n)
				begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					filt_reg <= 1'b0;
				end
				else
				begin
					s1_reg <= (g == 0) ? i_oc_fault : i_uc_fault;
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						filt_reg <= s3_reg;
				end
			end
			assign fault_filt[g] = filt_reg;
		end
	endgenerate
	// Overcurrent wins when both trip together
	logic in_run, oc_event, uc_event, fault_event, restart;
	logic [7:0] sel_cfg;
	logic [1:0] sel_mode;
	logic [2:0] sel_count, eff_left;
	logic [TIMER_W-1:0] delay_load;
	assign in_run = (state_reg == ST_RUN) && i_output_on;
	assign oc_event = in_run && fault_filt[0];
	assign uc_event = in_run && fault_filt[1] && !fault_filt[0];
	assign fault_event = oc_event || uc_event;
	assign sel_cfg = oc_event ? oc_cfg_reg : uc_cfg_reg;
	assign sel_mode = sel_cfg[`RESP_MODE_HI:`RESP_MODE_LO];
	assign sel_count = sel_cfg[`RETRY_CNT_HI:`RETRY_CNT_LO];
	// Remaining attempts carry across restarts of one retry sequence
	assign eff_left = retry_active_reg ? retries_left_reg : sel_count;
	assign delay_load = TIMER_W'((32'(sel_cfg[`RETRY_TIME_HI:`RETRY_TIME_LO]) + 32'h1)
		* RETRY_UNIT_CYCLES);
	assign restart = (state_reg == ST_DELAY) && i_output_on && (timer_reg == TIMER_W'(1));
	// Command access
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			oc_cfg_reg <= `REACTION_RESET;
			uc_cfg_reg <= `REACTION_RESET;
		end
		else if (i_wr_stb)
		begin
			if (i_cmd_code == `CMD_OC_REACTION)
				oc_cfg_reg <= i_wr_data;
			if (i_cmd_code == `CMD_UC_REACTION)
				uc_cfg_reg <= i_wr_data;
		end
	end
	logic code_known;
	assign code_known = (i_cmd_code == `CMD_OC_REACTION) || (i_cmd_code == `CMD_UC_REACTION);
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
			o_cmd_nack <= 1'b0;
		end
		else
		begin
			o_rd_valid <= i_rd_stb && code_known;
			o_cmd_nack <= (i_rd_stb || i_wr_stb) && !code_known;
			if (i_rd_stb)
				o_rd_data <= (i_cmd_code == `CMD_OC_REACTION) ? oc_cfg_reg :
					(i_cmd_code == `CMD_UC_REACTION) ? uc_cfg_reg : 8'h00;
		end
	end
	// Output sequencing
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF:
				if (i_output_on)
					state_next = ST_RUN;
			ST_RUN:
				if (!i_output_on)
					state_next = ST_OFF;
				else if (fault_event)
				begin
					if (sel_mode == `MODE_RETRY)
						state_next = (eff_left == `RETRY_NONE) ? ST_LATCH : ST_DELAY;
					else if (sel_mode == `MODE_RESUME)
						state_next = ST_RESUME;
					else
						state_next = ST_LATCH;
				end
			ST_DELAY:
				if (!i_output_on)
					state_next = ST_OFF;
				else if (restart)
					state_next = ST_RUN;
			ST_LATCH:
				if (!i_output_on)
					state_next = ST_OFF;
				else if (i_clear_faults)
					state_next = ST_RUN;
			ST_RESUME:
				if (!i_output_on)
					state_next = ST_OFF;
				else if (!fault_filt[cause_uc_reg])
					state_next = ST_RUN;
			default:
				state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_OFF;
			out_en_reg <= 1'b0;
			cause_uc_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			out_en_reg <= (state_next == ST_RUN);
			if (fault_event)
				cause_uc_reg <= uc_event;
		end
	end
	// Retry bookkeeping; count 111 never decrements
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			retry_active_reg <= 1'b0;
			retries_left_reg <= 3'h0;
		end
		else if (state_reg == ST_OFF || i_clear_faults)
			retry_active_reg <= 1'b0;
		else if (fault_event && sel_mode == `MODE_RETRY)
		begin
			retry_active_reg <= 1'b1;
			retries_left_reg <= eff_left;
		end
		else if (restart && retries_left_reg != `RETRY_ENDLESS)
			retries_left_reg <= retries_left_reg - 3'h1;
	end
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			timer_reg <= '0;
		else if (fault_event)
			timer_reg <= delay_load;
		else if (state_reg == ST_DELAY && timer_reg != '0)
			timer_reg <= timer_reg - TIMER_W'(1);
	end
	// Sticky status: a new fault in the clearing cycle wins
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			stat_oc_reg <= 1'b0;
			stat_uc_reg <= 1'b0;
			alert_n_reg <= 1'b1;
		end
		else
		begin
			stat_oc_reg <= oc_event || (stat_oc_reg && !i_clear_faults);
			stat_uc_reg <= uc_event || (stat_uc_reg && !i_clear_faults);
			alert_n_reg <= !(fault_event ||
				((stat_oc_reg || stat_uc_reg) && !i_clear_faults));
		end
	end
	assign o_output_enable = out_en_reg;
	assign o_status_oc = stat_oc_reg;
	assign o_status_uc = stat_uc_reg;
	assign o_alert_line_n = alert_n_reg;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_oc_write;
		i_wr_stb && i_cmd_code == `CMD_OC_REACTION;
	endsequence
	sequence s_uc_write;
		i_wr_stb && i_cmd_code == `CMD_UC_REACTION;
	endsequence
	chk_oc_cfg_write: assert property (
		s_oc_write |=> oc_cfg_reg == $past(i_wr_data))
		else $error("overcurrent reaction not written");
	chk_oc_cfg_read: assert property (i_rd_stb && i_cmd_code == `CMD_OC_REACTION
		|=> o_rd_valid && o_rd_data == $past(oc_cfg_reg))
		else $error("overcurrent reaction read mismatch");
	chk_uc_cfg_write: assert property (
		s_uc_write |=> uc_cfg_reg == $past(i_wr_data))
		else $error("undercurrent reaction not written");
	chk_oc_status_set: assert property (
		oc_event |=> o_status_oc && !o_alert_line_n)
		else $error("overcurrent status not set");
	chk_uc_status_set: assert property (
		uc_event |=> o_status_uc && !o_alert_line_n)
		else $error("undercurrent status not set");
	chk_alert_low_held: assert property ((o_status_oc || o_status_uc) && !i_clear_faults
		|=> !o_alert_line_n)
		else $error("alert not held low while status set");
	chk_retry_disable: assert property (fault_event && sel_mode == `MODE_RETRY
		|=> !o_output_enable)
		else $error("output not disabled on retry fault");
	chk_resume_enable: assert property (state_reg == ST_RESUME && i_output_on &&
		!fault_filt[cause_uc_reg] |=> o_output_enable && state_reg == ST_RUN)
		else $error("output not resumed after fault cleared");
	chk_retry_count: assert property (restart && retries_left_reg != `RETRY_ENDLESS &&
		!i_clear_faults |=> retries_left_reg == $past(retries_left_reg) - 3'h1)
		else $error("retry count not decremented");
	chk_retry_zero: assert property (fault_event && sel_mode == `MODE_RETRY &&
		eff_left == `RETRY_NONE |=> state_reg == ST_LATCH && !o_output_enable)
		else $error("zero retry count did not latch off");
	chk_retry_endless: assert property (restart && retries_left_reg == `RETRY_ENDLESS
		|=> retries_left_reg == `RETRY_ENDLESS && o_output_enable)
		else $error("endless retry lost its count");
	chk_retry_delay: assert property (fault_event && state_next == ST_DELAY
		|=> timer_reg == $past(delay_load) && state_reg == ST_DELAY)
		else $error("retry delay not loaded");
	chk_undef_mode: assert property (fault_event && !sel_mode[1]
		|=> state_reg == ST_LATCH && !o_alert_line_n)
		else $error("undefined mode did not latch off");

endmodule : current_fault_response_control

// file: dv/cmd_host_model.sv
/*
 Command host model: issues single-byte reads and writes of reaction bytes.
 Assumes the controller's strobe port shape, all on i_core_clk.
*/
`timescale 1ns/100ps
module cmd_host_model (
	// Clock
	input wire logic i_core_clk,
	// Command side
	output logic [7:0] o_cmd_code,
	output logic o_wr_stb,
	output logic [7:0] o_wr_data,
	output logic o_rd_stb
);
	initial
	begin
		o_cmd_code = 8'h00;
		o_wr_stb = 1'b0;
		o_wr_data = 8'h00;
		o_rd_stb = 1'b0;
	end
	// Released code and data are inverted so stale values never pass
	task access(input logic w, input logic [7:0] c, input logic [7:0] d);
		@(posedge i_core_clk);
		o_cmd_code <= c;
		o_wr_data <= d;
		o_wr_stb <= w;
		o_rd_stb <= !w;
		@(posedge i_core_clk);
		o_wr_stb <= 1'b0;
		o_rd_stb <= 1'b0;
		o_cmd_code <= ~c;
		o_wr_data <= ~d;
		#1;
	endtask : access
endmodule : cmd_host_model

// file: dv/tb_top.sv
/*
 Self-checking bench for the current fault response controller.
 Assumes cmd_host_model on the command port and a short retry unit.
*/
`timescale 1ns/100ps
`include "fault_resp_map.svh"
module tb_top;
	localparam int U = 4;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_output_on = 1'b0;
	logic i_clear_faults = 1'b0;
	logic i_oc_fault = 1'b0;
	logic i_uc_fault = 1'b0;
	logic [7:0] i_cmd_code, i_wr_data, o_rd_data;
	logic i_wr_stb, i_rd_stb, o_rd_valid, o_cmd_nack;
	logic o_output_enable, o_status_oc, o_status_uc, o_alert_line_n;
	int fails = 0;
	int checked = 0;
	int n;

	cmd_host_model host (.i_core_clk(i_core_clk), .o_cmd_code(i_cmd_code),
		.o_wr_stb(i_wr_stb), .o_wr_data(i_wr_data), .o_rd_stb(i_rd_stb));
	current_fault_response_control #(.RETRY_UNIT_CYCLES(U)) uut (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_cmd_code(i_cmd_code), .i_wr_stb(i_wr_stb),
		.i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .o_cmd_nack(o_cmd_nack), .i_output_on(i_output_on),
		.i_clear_faults(i_clear_faults), .i_oc_fault(i_oc_fault), .i_uc_fault(i_uc_fault),
		.o_output_enable(o_output_enable), .o_status_oc(o_status_oc),
		.o_status_uc(o_status_uc), .o_alert_line_n(o_alert_line_n));

	initial
	begin
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Flags as {status_oc, status_uc, alert_n, enable}
	task fl(input logic [3:0] e);
		chk({o_status_oc, o_status_uc, o_alert_line_n, o_output_enable}, e);
	endtask : fl
	// Expected as {valid, nack, data}
	task rd(input logic [7:0] c, input logic [9:0] e);
		host.access(1'b0, c, 8'h00);
		chk({o_rd_valid, o_cmd_nack, o_rd_data}, e);
	endtask : rd
	// n ends at lim when the level never shows, so lim must differ from any figure
	task wt(input logic v, input int lim);
		n = lim;
		for (int k = 1; k <= lim; k++)
		begin
			@(posedge i_core_clk);
			#1;
			if (o_output_enable === v)
			begin
				n = k;
				break;
			end
		end
	endtask : wt
	task arm;
		@(posedge i_core_clk);
		i_output_on <= 1'b0;
		i_clear_faults <= 1'b1;
		@(posedge i_core_clk);
		i_output_on <= 1'b1;
		i_clear_faults <= 1'b0;
		wt(1'b1, 8);
	endtask : arm
	task flt(input logic oc, input logic uc);
		@(posedge i_core_clk);
		i_oc_fault <= oc;
		i_uc_fault <= uc;
	endtask : flt
	task print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	initial
	begin
		repeat (5000) @(posedge i_core_clk);
		fails++;
		print_verdict();
	end

	initial
	begin
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		#1;
		fl(4'h2);
		rd(`CMD_OC_REACTION, 10'h280);
		rd(`CMD_UC_REACTION, 10'h280);
		host.access(1'b1, `CMD_OC_REACTION, 8'ha5);
		host.access(1'b1, `CMD_UC_REACTION, 8'h5a);
		rd(`CMD_OC_REACTION, 10'h2a5);
		rd(`CMD_UC_REACTION, 10'h25a);
		rd(8'he7, 10'h100);
		$display("test registers done");
		// Resume mode on overcurrent
		host.access(1'b1, `CMD_OC_REACTION, 8'hc0);
		arm();
		flt(1'b1, 1'b0);
		wt(1'b0, 8);
		fl(4'h8);
		flt(1'b0, 1'b0);
		wt(1'b1, 12);
		fl(4'h9);
		$display("test resume done");
		// Retry once, delay two units, then latch
		host.access(1'b1, `CMD_UC_REACTION, 8'h89);
		arm();
		flt(1'b0, 1'b1);
		wt(1'b0, 8);
		fl(4'h4);
		wt(1'b1, 20);
		chk(n, 2 * U);
		wt(1'b0, 8);
		wt(1'b1, 30);
		chk(n, 30);
		flt(1'b0, 1'b0);
		// Let the filtered fault level drain before re-arming
		repeat (4) @(posedge i_core_clk);
		arm();
		chk(o_output_enable, 1'b1);
		wt(1'b0, 6);
		chk(n, 6);
		$display("test retry done");
		// Count zero never restarts even after the fault goes
		host.access(1'b1, `CMD_UC_REACTION, 8'h80);
		arm();
		flt(1'b0, 1'b1);
		wt(1'b0, 8);
		flt(1'b0, 1'b0);
		wt(1'b1, 30);
		chk(n, 30);
		arm();
		chk(o_output_enable, 1'b1);
		$display("test no retry done");
		// Endless retry, stopped only by commanding off
		host.access(1'b1, `CMD_UC_REACTION, 8'hb8);
		arm();
		flt(1'b0, 1'b1);
		repeat (4)
		begin
			wt(1'b0, 8);
			wt(1'b1, 20);
			chk(n, U);
		end
		@(posedge i_core_clk);
		i_output_on <= 1'b0;
		wt(1'b1, 30);
		chk(n, 30);
		flt(1'b0, 1'b0);
		$display("test endless done");
		// Undefined modes latch off despite a nonzero count
		for (int m = 0; m < 2; m++)
		begin
			host.access(1'b1, `CMD_UC_REACTION, {m[1:0], 6'h38});
			arm();
			flt(1'b0, 1'b1);
			wt(1'b0, 8);
			flt(1'b0, 1'b0);
			wt(1'b1, 30);
			chk(n, 30);
			fl(4'h4);
		end
		$display("test undefined modes done");
		print_verdict();
	end
endmodule : tb_top
